// ===== core/four_channel_capture_compare.sv
// four-channel capture/compare unit with Avalon-MM register slave
// What this block does
// - direction bit zero makes a channel an input capture channel.
// - active pin edge copies the free-running counter into the channel time register.
// - each capture sets the channel flag; interrupt only while its enable is set.
// - direction bit one makes a channel an output compare channel.
// - counter match sets, clears or toggles the pin and sets the channel flag.
// - mode and level bits choose the action; both zero disconnect the pin unless its channel 3 mask bit is set.
// - force bit performs the pin action at once without touching the flag.
// - channel 3 match overrides others, driving masked-in channel 3 data bits.
// - with reset enable, channel 3 match clears the counter regardless of pin use.
// - port writes on compare pins go to a latch, shown once pin is free.
// - five interrupt outputs (four channels plus overflow) and irq, their union.
// - channel interrupt is high after an event while its enable is set.
// - overflow interrupt is high after rollover while its enable is set.
// - prescaler divides clock by 1 to 128 from a three-bit select.
// - overflow flag sets on rollover to zero; writing one clears it.
// - time registers read anytime; writes count only for compare channels.
//
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`default_nettype none
module four_channel_capture_compare (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [3:0] chan_pin_in,
  output logic [3:0] chan_pin_out,
  output logic [3:0] chan_pin_oe_n,
  output logic [3:0] chan_irq,
  output logic overflow_irq,
  output logic irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  capcmp_pkg::bus_state_e bus_state_r, bus_state_nxt;
  logic [31:0] readdata_r, readdata_nxt;
  logic waitreq_r, waitreq_nxt;
  capcmp_pkg::ctrl_s ctrl_r, ctrl_nxt;
  logic [7:0] action_r, action_nxt;
  logic [3:0] mask_r, mask_nxt;
  logic [3:0] data3_r, data3_nxt;
  logic [4:0] irq_en_r, irq_en_nxt;
  logic [4:0] flag_r, flag_nxt;
  logic [3:0] port_r, port_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [6:0] presc_r, presc_nxt;
  logic new_cnt_r, new_cnt_nxt;
  logic [15:0] tc_r [4];
  logic [15:0] tc_nxt [4];
  logic [3:0] cmp_r, cmp_nxt;
  logic [3:0] pin_out_r, pin_out_nxt;
  logic [3:0] pin_oe_n_r, pin_oe_n_nxt;
  logic [3:0] chan_irq_r, chan_irq_nxt;
  logic ovf_irq_r, ovf_irq_nxt;
  logic irq_r, irq_nxt;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  logic accept;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic [31:0] rd_mux;

  assign accept = (avs_read | avs_write) & (bus_state_r == capcmp_pkg::BUS_ANSWER);
  assign wr = avs_write & accept;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wbits = avs_writedata & wmask;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  // ------------------------------------------------------------
  // control word layout
  // ------------------------------------------------------------
  logic [31:0] ctrl_word;
  logic [31:0] ctrl_wr;

  // fields sit at their register positions, unused bits read 0
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[capcmp_pkg::CTRL_DIR_LSB +: 4] = ctrl_r.channel_direction_select;
    ctrl_word[capcmp_pkg::CTRL_PRESC_LSB +: 3] = ctrl_r.prescale_select;
    ctrl_word[capcmp_pkg::CTRL_COUNTER_RESET_ON_CH3_ENABLE_BIT] = ctrl_r.counter_reset_on_ch3_enable;
    ctrl_word[capcmp_pkg::CTRL_RUN_BIT] = ctrl_r.run;
    ctrl_word[capcmp_pkg::CTRL_EDGE_LSB +: 8] = ctrl_r.edge_sel;
  end

  assign ctrl_wr = merge(ctrl_word, avs_writedata, wmask);

  always_comb begin
    case (avs_address)
      capcmp_pkg::REG_CTRL: rd_mux = ctrl_word;
      capcmp_pkg::REG_ACTION: rd_mux = {24'h000000, action_r};
      capcmp_pkg::REG_CH3_OVR: rd_mux = {20'h00000, data3_r, 4'h0, mask_r};
      capcmp_pkg::REG_IRQ_EN: rd_mux = {27'h0000000, irq_en_r};
      capcmp_pkg::REG_FLAGS: rd_mux = {27'h0000000, flag_r};
      capcmp_pkg::REG_COUNT: rd_mux = {16'h0000, cnt_r};
      capcmp_pkg::REG_PORT: rd_mux = {28'h0000000, port_r};
      capcmp_pkg::REG_TIME0: rd_mux = {16'h0000, tc_r[0]};
      capcmp_pkg::REG_TIME1: rd_mux = {16'h0000, tc_r[1]};
      capcmp_pkg::REG_TIME2: rd_mux = {16'h0000, tc_r[2]};
      capcmp_pkg::REG_TIME3: rd_mux = {16'h0000, tc_r[3]};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait cycle, then a single cycle with waitrequest low
  always_comb begin
    bus_state_nxt = bus_state_r;
    readdata_nxt = readdata_r;
    case (bus_state_r)
      capcmp_pkg::BUS_IDLE: begin
        if (avs_read | avs_write) begin
          bus_state_nxt = capcmp_pkg::BUS_ANSWER;
          // read data holds until the next read answer
          if (avs_read) begin
            readdata_nxt = rd_mux;
          end
        end
      end
      capcmp_pkg::BUS_ANSWER: begin
        bus_state_nxt = capcmp_pkg::BUS_IDLE;
      end
      default: begin
        bus_state_nxt = capcmp_pkg::BUS_IDLE;
      end
    endcase
    waitreq_nxt = (bus_state_nxt != capcmp_pkg::BUS_ANSWER);
  end

  // ------------------------------------------------------------
  // edge detection
  // ------------------------------------------------------------
  logic [3:0] rise;
  logic [3:0] fall;

  capture_edge_detect #(
    .WIDTH(capcmp_pkg::NUM_CH)
  ) u_edge (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in(chan_pin_in),
    .rise(rise),
    .fall(fall)
  );

  // ------------------------------------------------------------
  // prescaler and counter
  // ------------------------------------------------------------
  logic [7:0] presc_div;
  logic [6:0] presc_lim;
  logic tick;
  logic cnt_rst;
  logic ovf;
  logic [3:0] dir;
  logic [3:0] match;
  logic [3:0] cap;
  logic [3:0] force_hit;
  logic ch3_fire;

  assign dir = ctrl_r.channel_direction_select;
  assign presc_div = 8'h01 << ctrl_r.prescale_select;
  assign presc_lim = 7'(presc_div - 8'h01);
  assign tick = ctrl_r.run & (presc_r == presc_lim);
  // channel 3 clears the counter whatever its pin is used for
  assign cnt_rst = ctrl_r.counter_reset_on_ch3_enable & new_cnt_r & (cnt_r == tc_r[3]);
  assign ovf = tick & (cnt_r == capcmp_pkg::CNT_MAX) & ~cnt_rst;

  always_comb begin
    presc_nxt = presc_r;
    if (!ctrl_r.run || tick) begin
      presc_nxt = 7'h00;
    end else begin
      presc_nxt = presc_r + 7'h01;
    end
    cnt_nxt = cnt_r;
    if (cnt_rst) begin
      cnt_nxt = 16'h0000;
    end else if (tick) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
    new_cnt_nxt = cnt_rst | tick;
  end

  // ------------------------------------------------------------
  // per-channel capture, compare and pin
  // ------------------------------------------------------------
  function automatic logic apply_action(input logic [1:0] act, input logic cur);
    case (act)
      capcmp_pkg::ACT_TOGGLE: apply_action = ~cur;
      capcmp_pkg::ACT_CLEAR: apply_action = 1'b0;
      capcmp_pkg::ACT_SET: apply_action = 1'b1;
      default: apply_action = cur;
    endcase
  endfunction

  assign force_hit = wr && (avs_address == capcmp_pkg::REG_FORCE) ? wbits[3:0] & dir : 4'h0;
  assign ch3_fire = match[3] | force_hit[3];

  genvar n;
  generate
    for (n = 0; n < 4; n++) begin : g_ch
      logic [1:0] act;
      logic own;
      logic wr_tc;
      logic connected;
      assign act = action_r[2*n+1:2*n];
      assign match[n] = dir[n] & new_cnt_r & (cnt_r == tc_r[n]);
      assign cap[n] = ~dir[n] & ((rise[n] & ctrl_r.edge_sel[2*n]) |
                                 (fall[n] & ctrl_r.edge_sel[2*n+1]));
      assign wr_tc = wr && (avs_address == 6'(capcmp_pkg::REG_TIME0 + 6'(4*n)));
      // forced and real compares share the pin action
      assign own = (match[n] | force_hit[n]) ? apply_action(act, cmp_r[n]) : cmp_r[n];
      assign cmp_nxt[n] = (ch3_fire & mask_r[n]) ? data3_r[n] : own;
      assign connected = dir[n] & ((act != capcmp_pkg::ACT_DISCONNECT) | mask_r[n]);
      assign pin_out_nxt[n] = connected ? cmp_nxt[n] : port_nxt[n];
      assign pin_oe_n_nxt[n] = ~dir[n];
      always_comb begin
        tc_nxt[n] = tc_r[n];
        if (cap[n]) begin
          tc_nxt[n] = cnt_r;
        end else if (wr_tc && dir[n]) begin
          tc_nxt[n] = 16'(merge({16'h0000, tc_r[n]}, avs_writedata, wmask));
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // registers written by software, flags and interrupts
  // ------------------------------------------------------------
  logic [4:0] flag_set;
  logic [4:0] flag_clr;

  assign flag_set = {ovf, cap | match};
  assign flag_clr = wr && (avs_address == capcmp_pkg::REG_FLAGS) ? wbits[4:0] : 5'h00;

  always_comb begin
    ctrl_nxt = ctrl_r;
    action_nxt = action_r;
    mask_nxt = mask_r;
    data3_nxt = data3_r;
    irq_en_nxt = irq_en_r;
    port_nxt = port_r;
    if (wr) begin
      case (avs_address)
        capcmp_pkg::REG_CTRL: begin
          ctrl_nxt.channel_direction_select = ctrl_wr[capcmp_pkg::CTRL_DIR_LSB +: 4];
          ctrl_nxt.prescale_select = ctrl_wr[capcmp_pkg::CTRL_PRESC_LSB +: 3];
          ctrl_nxt.counter_reset_on_ch3_enable = ctrl_wr[capcmp_pkg::CTRL_COUNTER_RESET_ON_CH3_ENABLE_BIT];
          ctrl_nxt.run = ctrl_wr[capcmp_pkg::CTRL_RUN_BIT];
          ctrl_nxt.edge_sel = ctrl_wr[capcmp_pkg::CTRL_EDGE_LSB +: 8];
        end
        capcmp_pkg::REG_ACTION: action_nxt = 8'(merge({24'h0, action_r}, avs_writedata, wmask));
        capcmp_pkg::REG_CH3_OVR: begin
          mask_nxt = 4'(merge({28'h0, mask_r}, avs_writedata, wmask));
          data3_nxt = 4'(merge({28'h0, data3_r}, avs_writedata >> capcmp_pkg::CH3_DATA_LSB,
                               wmask >> capcmp_pkg::CH3_DATA_LSB));
        end
        capcmp_pkg::REG_IRQ_EN: irq_en_nxt = 5'(merge({27'h0, irq_en_r}, avs_writedata, wmask));
        capcmp_pkg::REG_PORT: port_nxt = 4'(merge({28'h0, port_r}, avs_writedata, wmask));
        default: begin
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    flag_nxt = (flag_r & ~flag_clr) | flag_set;
    chan_irq_nxt = flag_nxt[3:0] & irq_en_nxt[3:0];
    ovf_irq_nxt = flag_nxt[capcmp_pkg::OVF_BIT] & irq_en_nxt[capcmp_pkg::OVF_BIT];
    irq_nxt = |(flag_nxt & irq_en_nxt);
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bus_state_r <= capcmp_pkg::BUS_IDLE;
      readdata_r <= capcmp_pkg::RST_WORD;
      waitreq_r <= 1'b1;
      ctrl_r <= 17'h00000;
      action_r <= 8'h00;
      mask_r <= 4'h0;
      data3_r <= 4'h0;
      irq_en_r <= 5'h00;
      flag_r <= 5'h00;
      port_r <= 4'h0;
      cnt_r <= 16'h0000;
      presc_r <= 7'h00;
      new_cnt_r <= 1'b0;
      for (int k = 0; k < 4; k++) begin
        tc_r[k] <= capcmp_pkg::RST_TIME;
      end
      cmp_r <= 4'h0;
      pin_out_r <= 4'h0;
      pin_oe_n_r <= 4'hf;
      chan_irq_r <= 4'h0;
      ovf_irq_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      bus_state_r <= bus_state_nxt;
      readdata_r <= readdata_nxt;
      waitreq_r <= waitreq_nxt;
      ctrl_r <= ctrl_nxt;
      action_r <= action_nxt;
      mask_r <= mask_nxt;
      data3_r <= data3_nxt;
      irq_en_r <= irq_en_nxt;
      flag_r <= flag_nxt;
      port_r <= port_nxt;
      cnt_r <= cnt_nxt;
      presc_r <= presc_nxt;
      new_cnt_r <= new_cnt_nxt;
      for (int k = 0; k < 4; k++) begin
        tc_r[k] <= tc_nxt[k];
      end
      cmp_r <= cmp_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_n_r <= pin_oe_n_nxt;
      chan_irq_r <= chan_irq_nxt;
      ovf_irq_r <= ovf_irq_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign avs_readdata = readdata_r;
  assign avs_waitrequest = waitreq_r;
  assign chan_pin_out = pin_out_r;
  assign chan_pin_oe_n = pin_oe_n_r;
  assign chan_irq = chan_irq_r;
  assign overflow_irq = ovf_irq_r;
  assign irq = irq_r;

endmodule
`default_nettype wire

// ===== core/capcmp_pkg.sv
// package: register map, field layout, reset values and types of the capture/compare unit
package capcmp_pkg;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int NUM_CH = 4;
  localparam int CNT_W = 16;
  localparam int PRESC_W = 7;
  localparam int ADDR_W = 6;
  localparam int SYNC_STAGES = 2;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_ACTION = 6'h04;
  localparam logic [5:0] REG_FORCE = 6'h08;
  localparam logic [5:0] REG_CH3_OVR = 6'h0c;
  localparam logic [5:0] REG_IRQ_EN = 6'h10;
  localparam logic [5:0] REG_FLAGS = 6'h14;
  localparam logic [5:0] REG_COUNT = 6'h18;
  localparam logic [5:0] REG_PORT = 6'h1c;
  localparam logic [5:0] REG_TIME0 = 6'h20;
  localparam logic [5:0] REG_TIME1 = 6'h24;
  localparam logic [5:0] REG_TIME2 = 6'h28;
  localparam logic [5:0] REG_TIME3 = 6'h2c;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_DIR_LSB = 0;
  localparam int CTRL_PRESC_LSB = 4;
  localparam int CTRL_COUNTER_RESET_ON_CH3_ENABLE_BIT = 7;
  localparam int CTRL_RUN_BIT = 8;
  localparam int CTRL_EDGE_LSB = 16;
  localparam int CH3_DATA_LSB = 8;
  localparam int OVF_BIT = 4;

  // ------------------------------------------------------------
  // reset values and action codes
  // ------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_TIME = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [1:0] ACT_DISCONNECT = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_e;

  typedef struct packed {
    logic [7:0] edge_sel;
    logic run;
    logic counter_reset_on_ch3_enable;
    logic [2:0] prescale_select;
    logic [3:0] channel_direction_select;
  } ctrl_s;

endpackage

// ===== core/capture_edge_detect.sv
// two-stage pin synchroniser with rising and falling edge detection
`timescale 1ns/10ps
`default_nettype none
module capture_edge_detect #(
  parameter int WIDTH = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  // ------------------------------------------------------------
  // per-pin synchroniser
  // ------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      logic meta_r;
      logic sync_r;
      logic prev_r;
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
          prev_r <= 1'b0;
        end else begin
          meta_r <= pin_in[i];
          sync_r <= meta_r;
          prev_r <= sync_r;
        end
      end
      // pulses held over two clocks survive the two-flop delay
      assign rise[i] = sync_r & ~prev_r;
      assign fall[i] = ~sync_r & prev_r;
    end
  endgenerate

endmodule
`default_nettype wire

// ===== testbench/capcmp_checker.sv
// port-level assertions for the capture/compare unit
`timescale 1ns/10ps
`default_nettype none
module capcmp_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [3:0] chan_pin_in,
  input wire logic [3:0] chan_pin_out,
  input wire logic [3:0] chan_pin_oe_n,
  input wire logic [3:0] chan_irq,
  input wire logic overflow_irq,
  input wire logic irq
);
  logic [3:0] dir_r, dir_nxt;
  logic [4:0] en_r, en_nxt;
  logic [1:0] age_r, age_nxt;
  logic done;
  assign done = avs_write && !avs_waitrequest && avs_byteenable[0];
  // shadow of direction and enable bits, with cycles since last write
  always_comb begin
    dir_nxt = dir_r;
    en_nxt = en_r;
    age_nxt = (age_r == 2'h3) ? age_r : age_r + 2'h1;
    if (done) begin
      age_nxt = 2'h0;
    end
    if (done && avs_address == 6'h00) begin
      dir_nxt = avs_writedata[3:0];
    end
    if (done && avs_address == 6'h10) begin
      en_nxt = avs_writedata[4:0];
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dir_r <= 4'h0;
      en_r <= 5'h00;
      age_r <= 2'h3;
    end else begin
      dir_r <= dir_nxt;
      en_r <= en_nxt;
      age_r <= age_nxt;
    end
  end
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  a_wait_single: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("wait low twice");
  a_wait_answer: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer");
  a_read_quiet: assert property (
    $changed(avs_readdata) |-> avs_read && !avs_waitrequest) else $error("readdata moved");
  a_unmapped_zero: assert property (
    avs_read && !avs_waitrequest && (avs_address >= 6'h30 || avs_address == 6'h08)
    |-> avs_readdata == 32'h0) else $error("nonzero read");
  a_irq_union: assert property (
    irq == (|chan_irq || overflow_irq)) else $error("irq not union");
  a_chan_masked: assert property (
    age_r == 2'h3 |-> (chan_irq & ~en_r[3:0]) == 4'h0) else $error("masked chan irq");
  a_ovf_masked: assert property (
    age_r == 2'h3 && !en_r[4] |-> !overflow_irq) else $error("masked ovf irq");
  a_oe_follows_dir: assert property (
    age_r == 2'h3 |-> chan_pin_oe_n == ~dir_r) else $error("oe_n vs direction");
  a_reset_state: assert property (
    disable iff (1'b0) !rst_n |=> avs_waitrequest && chan_pin_oe_n == 4'hf && !irq
    && chan_irq == 4'h0 && !overflow_irq) else $error("reset state");
endmodule
bind four_channel_capture_compare capcmp_checker chk_i (.core_clk(core_clk), .rst_n(rst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out), .chan_pin_oe_n(chan_pin_oe_n),
  .chan_irq(chan_irq), .overflow_irq(overflow_irq), .irq(irq));
`default_nettype wire

// ===== testbench/pin_source.sv
// far side of the channel pins: event sources and loads
`timescale 1ns/10ps
`default_nettype none
module pin_source (
  input wire logic [3:0] drive_lvl,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe_n,
  output logic [3:0] pin_level
);
  // a driven pin reads back the block's level, a released one the source
  assign pin_level = (pin_out & ~pin_oe_n) | (drive_lvl & pin_oe_n);
endmodule
`default_nettype wire

// ===== testbench/four_channel_capture_compare_bench.sv
// self-checking bench for the capture/compare unit
`timescale 1ns/10ps
`default_nettype none
module four_channel_capture_compare_bench;
  logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest, overflow_irq, irq;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, w;
  logic [3:0] avs_byteenable, pin_in, pin_out, pin_oe_n, chan_irq, src;
  logic [1:0] acts [4] = '{2'h2, 2'h1, 2'h1, 2'h3};
  logic [3:0] pins = 4'b1010;
  int n_errors, n_compared;
  four_channel_capture_compare dut (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .chan_pin_in(pin_in),
    .chan_pin_out(pin_out), .chan_pin_oe_n(pin_oe_n), .chan_irq(chan_irq),
    .overflow_irq(overflow_irq), .irq(irq));
  pin_source far (.drive_lvl(src), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_in));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic rst();
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
  endtask
  // one register cycle; read data lands in q
  task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= !we;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic t_regs();
    for (int a = 0; a < 64; a += 4) begin
      if (a >= 32) bus(1, 6'(a), 32'h1234);
      bus(0, 6'(a), 0);
      chk(q, 0);
    end
    bus(1, 6'h08, 32'hf);
    bus(0, 6'h08, 0);
    chk(q, 0);
    chk(pin_oe_n, 4'hf);
  endtask
  task automatic t_capture();
    bus(1, 6'h00, 32'h100);
    repeat (40) @(posedge core_clk);
    bus(1, 6'h00, 32'h10000);
    bus(0, 6'h18, 0);
    w = q;
    bus(1, 6'h10, 32'h1);
    src <= 4'h1;
    repeat (4) @(posedge core_clk);
    src <= 4'h0;
    repeat (20) if (chan_irq[0] !== 1'b1) @(posedge core_clk);
    chk(chan_irq, 4'h1);
    bus(0, 6'h20, 0);
    chk(q, w);
    bus(1, 6'h10, 32'h0);
    chk(chan_irq, 4'h0);
    bus(0, 6'h14, 0);
    chk(q, 32'h1);
    bus(1, 6'h14, 32'h1);
    bus(0, 6'h14, 0);
    chk(q, 0);
    // falling edge only on channel 0
    bus(1, 6'h00, 32'h20000);
    src <= 4'h1;
    repeat (8) @(posedge core_clk);
    bus(0, 6'h14, 0);
    chk(q, 0);
    src <= 4'h0;
    repeat (8) @(posedge core_clk);
    bus(0, 6'h14, 0);
    chk(q, 32'h1);
  endtask
  task automatic t_compare();
    bus(1, 6'h00, 32'h2);
    bus(1, 6'h24, 32'h40);
    bus(1, 6'h04, 32'hc);
    bus(1, 6'h10, 32'h2);
    bus(1, 6'h00, 32'h102);
    chk(pin_oe_n, 4'hd);
    chk(pin_out[1], 0);
    repeat (100) if (pin_out[1] !== 1'b1) @(posedge core_clk);
    chk(pin_out[1], 1);
    chk(chan_irq, 4'h2);
    bus(0, 6'h14, 0);
    chk(q, 32'h2);
    bus(1, 6'h14, 32'h2);
    for (int i = 0; i < 4; i++) begin
      bus(1, 6'h04, {28'h0, acts[i], 2'h0});
      bus(1, 6'h08, 32'h2);
      repeat (3) @(posedge core_clk);
      chk(pin_out[1], pins[i]);
    end
    bus(0, 6'h14, 0);
    chk(q, 0);
    bus(1, 6'h04, 32'h8);
    bus(1, 6'h08, 32'h2);
    bus(1, 6'h1c, 32'h2);
    chk(pin_out[1], 0);
    bus(1, 6'h04, 32'h0);
    repeat (3) @(posedge core_clk);
    chk(pin_out[1], 1);
  endtask
  task automatic t_ch3();
    bus(1, 6'h00, 32'ha);
    bus(1, 6'h24, 32'h30);
    bus(1, 6'h2c, 32'h30);
    bus(1, 6'h0c, 32'h202);
    bus(1, 6'h04, 32'h8);
    bus(1, 6'h00, 32'h18a);
    repeat (200) @(posedge core_clk);
    chk(pin_out[1], 1);
    bus(0, 6'h18, 0);
    chk(q < 32'h40, 1);
    bus(1, 6'h00, 32'h182);
    repeat (200) @(posedge core_clk);
    bus(0, 6'h18, 0);
    chk(q < 32'h40, 1);
  endtask
  task automatic t_count();
    for (int s = 0; s < 8; s++) begin
      bus(0, 6'h18, 0);
      w = q;
      bus(1, 6'h00, {23'h0, 1'b1, 1'b0, 3'(s), 4'h0});
      repeat (512) @(posedge core_clk);
      bus(1, 6'h00, 0);
      bus(0, 6'h18, 0);
      chk((q - w) >= (512 >> s) && (q - w) <= (524 >> s) + 1, 1);
    end
    bus(1, 6'h10, 32'h10);
    bus(1, 6'h00, 32'h100);
    repeat (70000) if (overflow_irq !== 1'b1) @(posedge core_clk);
    chk(overflow_irq, 1);
    bus(0, 6'h14, 0);
    chk(q, 32'h10);
    bus(1, 6'h14, 32'h10);
    bus(0, 6'h14, 0);
    chk(q, 0);
  endtask
  initial begin
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    src = 4'h0;
    rst();
    t_regs();
    t_capture();
    rst();
    t_compare();
    rst();
    t_ch3();
    rst();
    t_count();
    end_of_test();
  end
  initial begin
    #400000;
    n_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
